// File: include/pulse_width_capture_cfg.svh
// Constants of the pulse width capture channel.
`ifndef PULSE_WIDTH_CAPTURE_CFG_SVH
`define PULSE_WIDTH_CAPTURE_CFG_SVH
`define PWC_OFF_ENABLE 12'h000
`define PWC_OFF_RUN 12'h004
`define PWC_OFF_MODE 12'h008
`define PWC_OFF_FFCTL 12'h00C
`define PWC_OFF_CAP_RISE 12'h010
`define PWC_OFF_CAP_FALL 12'h014
`define PWC_OFF_CNT 12'h018
`define PWC_OFF_STATUS 12'h01C
`define PWC_OFF_IRQ_EN 12'h020
`define PWC_OFF_IRQ_CLR 12'h024
`define PWC_RUN_CNT_BIT 0
`define PWC_RUN_PRE_BIT 2
`define PWC_EN_BIT 7
`define PWC_MODE_CLK_LSB 0
`define PWC_MODE_CLR_BIT 3
`define PWC_MODE_CPM_LSB 4
`define PWC_MODE_CAP_BOTH 2'h2
`define PWC_FF_INIT_LSB 0
`define PWC_FF_INIT_ZERO 2'h2
`define PWC_FF_INIT_ONE 2'h1
`define PWC_MODE_RST 8'h00
`define PWC_FFCTL_RST 8'h03
`define PWC_PRE_W 8
`endif

// File: include/pulse_width_capture_pkg.sv
// Types of the pulse width capture channel.
package pulse_width_capture_pkg;
  typedef logic [15:0] count_t;
  typedef struct packed {
    logic [1:0] sync;
    logic prev;
  } edge_state_s;
endpackage : pulse_width_capture_pkg

// File: hdl/capture_edge_detect.sv
// Synchroniser and edge detector for the capture input pin.
module capture_edge_detect (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);
  pulse_width_capture_pkg::edge_state_s st_q;
  pulse_width_capture_pkg::edge_state_s st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.sync = {st_q.sync[0], pin_i};
    st_d.prev = st_q.sync[1];
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rise_o = st_q.sync[1] & ~st_q.prev;
  assign fall_o = ~st_q.sync[1] & st_q.prev;
endmodule : capture_edge_detect

// File: hdl/pulse_width_capture.sv
// Pulse width capture timer channel with an APB register slave.
//
// The APB slave port and the register addresses were decided locally.
`include "pulse_width_capture_cfg.svh"

// Functional notes
// - Capture mode 10 stores counter on rising and falling input edges.
// - Falling-edge capture raises the fall capture interrupt in the same cycle.
// - Rising-edge capture raises the rise capture interrupt.
// - Writing ones to run bits 2 and 0 starts prescaler and counter.
// - Writing zeros to run bits 2 and 0 halts prescaler and counter.
// - Flip-flop control holds output static, initial value loaded as zero (init code 10) or one (init code 01).
// - Counter runs free from selected prescaler output, never cleared by match.
module pulse_width_capture (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_input_pin_i,
  output logic timer_output_flipflop_o,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic enable;
    logic run_pre;
    logic run_cnt;
    logic [7:0] mode;
    logic [7:0] ffctl;
    logic ff;
    logic [`PWC_PRE_W-1:0] pre;
    pulse_width_capture_pkg::count_t cnt;
    pulse_width_capture_pkg::count_t cap_rise;
    pulse_width_capture_pkg::count_t cap_fall;
    logic [1:0] status;
    logic [1:0] irq_en;
    logic irq;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } core_state_s;

  core_state_s s_q;
  core_state_s s_d;
  logic rise;
  logic fall;
  logic tick;
  logic acc;
  logic wr;
  logic cap_both;
  logic [1:0] cap_ev;
  logic [2:0] clk_sel;

  capture_edge_detect u_edge (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(capture_input_pin_i),
    .rise_o(rise),
    .fall_o(fall)
  );

  // ---------------------------------------------------------------
  // Prescaler tick selection
  // ---------------------------------------------------------------
  always_comb
  begin
    clk_sel = s_q.mode[`PWC_MODE_CLK_LSB +: 3];
    unique case (clk_sel)
      3'h1: tick = 1'b1;
      3'h2: tick = &s_q.pre[1:0];
      3'h3: tick = &s_q.pre[4:0];
      3'h4: tick = &s_q.pre[7:0];
      default: tick = 1'b0;
    endcase
  end

  assign acc = psel & penable & ~s_q.ready;
  assign wr = acc & pwrite;
  assign cap_both = s_q.mode[`PWC_MODE_CPM_LSB +: 2] == `PWC_MODE_CAP_BOTH;
  assign cap_ev = {fall & cap_both & s_q.enable,
                   rise & cap_both & s_q.enable};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.ready = acc;
    s_d.err = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (s_q.enable && s_q.run_pre)
    begin
      s_d.pre = s_q.pre + 1'b1;
    end
    if (s_q.enable && s_q.run_cnt && s_q.run_pre && tick)
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    if (cap_ev[0])
    begin
      s_d.cap_rise = s_q.cnt;
    end
    if (cap_ev[1])
    begin
      s_d.cap_fall = s_q.cnt;
    end
    if (acc)
    begin
      unique case (paddr)
        `PWC_OFF_ENABLE:
        begin
          s_d.rdata = {24'h00_0000, s_q.enable, 7'h00};
          if (wr)
          begin
            s_d.enable = pwdata[`PWC_EN_BIT];
          end
        end
        `PWC_OFF_RUN:
        begin
          s_d.rdata = {29'h0000_0000, s_q.run_pre, 1'b0, s_q.run_cnt};
          if (wr)
          begin
            s_d.run_pre = pwdata[`PWC_RUN_PRE_BIT];
            s_d.run_cnt = pwdata[`PWC_RUN_CNT_BIT];
            if (!pwdata[`PWC_RUN_PRE_BIT])
            begin
              s_d.pre = '0;
            end
          end
        end
        `PWC_OFF_MODE:
        begin
          s_d.rdata = {24'h00_0000, s_q.mode};
          if (wr)
          begin
            s_d.mode = pwdata[7:0];
            if (pwdata[`PWC_MODE_CLR_BIT])
            begin
              s_d.cnt = '0;
            end
          end
        end
        `PWC_OFF_FFCTL:
        begin
          s_d.rdata = {24'h00_0000, s_q.ffctl};
          if (wr)
          begin
            s_d.ffctl = {pwdata[7:2], 2'h3};
            if (pwdata[`PWC_FF_INIT_LSB +: 2] == `PWC_FF_INIT_ZERO)
            begin
              s_d.ff = 1'b0;
            end
            else if (pwdata[`PWC_FF_INIT_LSB +: 2] == `PWC_FF_INIT_ONE)
            begin
              s_d.ff = 1'b1;
            end
          end
        end
        `PWC_OFF_CAP_RISE: s_d.rdata = {16'h0000, s_q.cap_rise};
        `PWC_OFF_CAP_FALL: s_d.rdata = {16'h0000, s_q.cap_fall};
        `PWC_OFF_CNT: s_d.rdata = {16'h0000, s_q.cnt};
        `PWC_OFF_STATUS: s_d.rdata = {30'h0000_0000, s_q.status};
        `PWC_OFF_IRQ_EN:
        begin
          s_d.rdata = {30'h0000_0000, s_q.irq_en};
          if (wr)
          begin
            s_d.irq_en = pwdata[1:0];
          end
        end
        `PWC_OFF_IRQ_CLR:
        begin
          if (wr)
          begin
            s_d.status = s_q.status & ~pwdata[1:0];
          end
        end
        default: s_d.err = 1'b1;
      endcase
    end
    s_d.status = s_d.status | cap_ev;
    s_d.irq = |(s_d.status & s_d.irq_en);
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
      s_q.mode <= `PWC_MODE_RST;
      s_q.ffctl <= `PWC_FFCTL_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign timer_output_flipflop_o = s_q.ff;
  assign irq_o = s_q.irq;

  // ---------------------------------------------------------------
  // Capture assertions
  // ---------------------------------------------------------------
  AST_CAP_RISE: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_ev[0] |=> s_q.cap_rise == $past(s_q.cnt))
    else $error("Rise capture did not store the counter.");

  AST_CAP_FALL: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_ev[1] |=> s_q.cap_fall == $past(s_q.cnt))
    else $error("Fall capture did not store the counter.");

  AST_CAP_MODE_ONLY: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !cap_both |=> $stable(s_q.cap_rise) && $stable(s_q.cap_fall))
    else $error("Capture happened outside the both-edge mode.");

  AST_CAP_NEEDS_ENABLE: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !s_q.enable |=> $stable(s_q.cap_rise) && $stable(s_q.cap_fall))
    else $error("Capture happened while the channel was disabled.");

  AST_FALL_IRQ: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_ev[1] |=> s_q.status[1])
    else $error("Fall capture did not flag its interrupt.");

  AST_FALL_IRQ_OUT: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_ev[1] && s_q.irq_en[1] |=> irq_o)
    else $error("Enabled fall capture did not raise the interrupt.");

  AST_FALL_STICKY: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    s_q.status[1] && !wr |=> s_q.status[1])
    else $error("Fall status cleared without a write.");

  AST_RISE_STATUS: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_ev[0] |=> s_q.status[0])
    else $error("Rise capture did not flag its interrupt.");

  AST_RISE_IRQ: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_ev[0] && s_q.irq_en[0] |=> irq_o)
    else $error("Enabled rise capture did not raise the interrupt.");

  AST_RISE_STICKY: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    s_q.status[0] && !wr |=> s_q.status[0])
    else $error("Rise status cleared without a write.");

  AST_IRQ_LEVEL: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    irq_o == |(s_q.status & s_q.irq_en))
    else $error("Interrupt output does not match enabled status.");

  AST_HOLD: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !cap_ev[0] && !cap_ev[1] |=> $stable(s_q.cap_rise)
      && $stable(s_q.cap_fall))
    else $error("Capture register changed without an edge.");

  // ---------------------------------------------------------------
  // Run control assertions
  // ---------------------------------------------------------------
  AST_START: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    wr && paddr == `PWC_OFF_RUN && pwdata[`PWC_RUN_PRE_BIT]
      && pwdata[`PWC_RUN_CNT_BIT] |=> s_q.run_pre && s_q.run_cnt)
    else $error("Run write did not start the counter.");

  AST_STOP: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    wr && paddr == `PWC_OFF_RUN && !pwdata[`PWC_RUN_PRE_BIT]
      && !pwdata[`PWC_RUN_CNT_BIT] |=> !s_q.run_pre && !s_q.run_cnt)
    else $error("Run write did not stop the counter.");

  AST_HALT: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !s_q.run_cnt |=> s_q.cnt == $past(s_q.cnt) || $past(wr))
    else $error("Counter moved while halted.");

  AST_PRE_HALT: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !s_q.run_pre |=> $stable(s_q.cnt) || $past(wr))
    else $error("Counter moved while the prescaler was halted.");

  AST_PRE_CLEAR: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !s_q.run_pre |-> s_q.pre == '0)
    else $error("Prescaler held a count while halted.");

  AST_FREE_RUN: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !$past(wr) |-> s_q.cnt == $past(s_q.cnt)
      || s_q.cnt == $past(s_q.cnt) + 16'h0001)
    else $error("Counter was cleared outside a mode write.");

  AST_COUNT_TICK: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    s_q.enable && s_q.run_pre && s_q.run_cnt && tick && !wr
      |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
    else $error("Counter missed a prescaler tick.");

  AST_NO_TICK: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !tick |=> $stable(s_q.cnt) || $past(wr))
    else $error("Counter moved without a prescaler tick.");

  // ---------------------------------------------------------------
  // Output flip-flop and bus assertions
  // ---------------------------------------------------------------
  AST_FF_STATIC: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !$past(wr) |-> $stable(timer_output_flipflop_o))
    else $error("Output flip-flop changed without a write.");

  AST_FF_LOAD_ZERO: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    wr && paddr == `PWC_OFF_FFCTL
      && pwdata[`PWC_FF_INIT_LSB +: 2] == `PWC_FF_INIT_ZERO
      |=> !timer_output_flipflop_o)
    else $error("Output flip-flop was not loaded with zero.");

  AST_READY_PULSE: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    pready |=> !pready)
    else $error("Ready stood longer than one cycle.");

  AST_ERR_WITH_READY: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    pslverr |-> pready)
    else $error("Error response came without ready.");
endmodule : pulse_width_capture

// File: tb/pulse_source.sv
// External pulse source that drives the capture input pin.
module pulse_source #(
  parameter int HIGH_LEN = 60,
  parameter int LOW_LEN = 50
) (
  input wire logic core_clk_i,
  input wire logic go_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Pulse train: high, low, high, then idle low.
  // ----------------------------------------
  initial
  begin
    pin_o = 1'b0;
    forever
    begin
      @(posedge go_i);
      @(posedge core_clk_i);
      pin_o <= 1'b1;
      repeat (HIGH_LEN) @(posedge core_clk_i);
      pin_o <= 1'b0;
      repeat (LOW_LEN) @(posedge core_clk_i);
      pin_o <= 1'b1;
      repeat (HIGH_LEN) @(posedge core_clk_i);
      pin_o <= 1'b0;
    end
  end
endmodule : pulse_source

// File: tb/testbench.sv
// Self-checking bench for the pulse width capture channel.
`include "pulse_width_capture_cfg.svh"
`define CHK(a, b) \
  begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t value mismatch", $time); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] H = 16'h003C;
  localparam logic [15:0] L = 16'h0032;
  logic core_clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr;
  logic pin, ff, irq, go, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r1, f1, r2;
  int n_fail, checked, cyc;
  // ----------------------------------------
  // Clock, design and pulse source.
  // ----------------------------------------
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  pulse_width_capture i_pulse_width_capture (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input_pin_i(pin),
    .timer_output_flipflop_o(ff), .irq_o(irq));
  pulse_source #(.HIGH_LEN(60), .LOW_LEN(50)) i_pulse_source (
    .core_clk_i(core_clk_i), .go_i(go), .pin_o(pin));
  // ----------------------------------------
  // APB tasks and closing report.
  // ----------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    @(posedge core_clk_i);
    while (pready !== 1'b1) @(posedge core_clk_i);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk
  task wait_st(input logic [31:0] m);
    int i;
    for (i = 0; i < 100; i++)
    begin
      apb(1'b0, `PWC_OFF_STATUS, 32'h0);
      if ((rd & m) === m) break;
    end
    `CHK(rd & m, m)
  endtask : wait_st
  task stop_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial
  begin
    sys_rst_i = 1'b1;
    {psel, penable, pwrite, go} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rdchk(`PWC_OFF_FFCTL, 32'h3);
    rdchk(`PWC_OFF_CNT, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b1, `PWC_OFF_ENABLE, 32'h80);
    apb(1'b1, `PWC_OFF_FFCTL, 32'h1);
    `CHK(ff, 1'b1)
    apb(1'b1, `PWC_OFF_FFCTL, 32'h2);
    `CHK(ff, 1'b0)
    apb(1'b1, `PWC_OFF_MODE, 32'h21);
    apb(1'b1, `PWC_OFF_IRQ_EN, 32'h2);
    apb(1'b1, `PWC_OFF_RUN, 32'h1);
    rdchk(`PWC_OFF_CNT, 32'h0);
    apb(1'b1, `PWC_OFF_RUN, 32'h5);
    apb(1'b0, `PWC_OFF_CNT, 32'h0);
    r1 = rd;
    apb(1'b0, `PWC_OFF_CNT, 32'h0);
    `CHK(rd[15:0] - r1[15:0], 16'h0004)
    go <= 1'b1;
    wait_st(32'h1);
    `CHK(irq, 1'b0)
    apb(1'b0, `PWC_OFF_CAP_RISE, 32'h0);
    r1 = rd;
    wait_st(32'h2);
    `CHK(irq, 1'b1)
    apb(1'b0, `PWC_OFF_CAP_FALL, 32'h0);
    f1 = rd;
    `CHK(f1[15:0] - r1[15:0], H)
    apb(1'b1, `PWC_OFF_IRQ_CLR, 32'h3);
    rdchk(`PWC_OFF_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    apb(1'b1, `PWC_OFF_IRQ_EN, 32'h3);
    wait_st(32'h1);
    `CHK(irq, 1'b1)
    apb(1'b0, `PWC_OFF_CAP_RISE, 32'h0);
    r2 = rd;
    `CHK(r2[15:0] - f1[15:0], L)
    wait_st(32'h2);
    apb(1'b0, `PWC_OFF_CAP_FALL, 32'h0);
    `CHK(rd[15:0] - r2[15:0], H)
    rdchk(`PWC_OFF_CAP_RISE, r2);
    apb(1'b1, `PWC_OFF_RUN, 32'h0);
    apb(1'b0, `PWC_OFF_CNT, 32'h0);
    r1 = rd;
    repeat (10) @(posedge core_clk_i);
    rdchk(`PWC_OFF_CNT, r1);
    apb(1'b1, `PWC_OFF_MODE, 32'h2A);
    rdchk(`PWC_OFF_CNT, 32'h0);
    apb(1'b1, `PWC_OFF_RUN, 32'h5);
    apb(1'b0, `PWC_OFF_CNT, 32'h0);
    r1 = rd;
    apb(1'b0, `PWC_OFF_CNT, 32'h0);
    `CHK(rd[15:0] - r1[15:0], 16'h0001)
    apb(1'b1, `PWC_OFF_MODE, 32'h20);
    apb(1'b0, `PWC_OFF_CNT, 32'h0);
    r1 = rd;
    apb(1'b0, `PWC_OFF_CNT, 32'h0);
    `CHK(rd[15:0] - r1[15:0], 16'h0000)
    `CHK(ff, 1'b0)
    stop_test();
  end
endmodule : testbench
